/* File: src/aux_cmd_ctrl.sv */
// module: aux output and ramp command interpreter behind an ahb-lite slave
//
// Functional notes
// R1: contour speed update applies next contour command, no ramp, range 1..1,043,999.
// R2: speed update without executing contour changes nothing.
// R3: auto aux, parameter zero: aux high at move start, low at move end.
// R4: auto aux, parameter nonzero: aux low at move start, high at end; one motor mode decodes only parameter bit 0.
// R5: with hold delay, wait settle time after move before complementing aux.
// R6: auto mode persists; aux on, aux off, force high, force low cancel it.
// R7: multi motor mode: only filled axes get auto aux, value sets polarity.
// R8: after reset auto aux mode is off on every axis.
// R9: auto aux queues one entry per axis, plus 3 with hold delay.
// R10: aux query reports enable and move level; only in one motor mode.
// R11: encoder report returns all axis positions at once, any mode.
// R12: linear ramp sets all axes linear, uses 11 queue entries; default.
// R13: host avoids linear ramp select while any axis moves.
// R14: force high drives aux high, cancels auto mode, one queue entry.
// R15: force low drives aux low and cancels auto mode.
// R16: out of range contour speed update is ignored.
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module aux_cmd_ctrl (
  input  wire logic                                       mclk_i,
  input  wire logic                                       sys_rst_i,
  // ahb-lite slave
  input  wire logic                                       hsel_i,
  input  wire logic [31:0]                                haddr_i,
  input  wire logic [1:0]                                 htrans_i,
  input  wire logic                                       hwrite_i,
  input  wire logic [2:0]                                 hsize_i,
  input  wire logic [31:0]                                hwdata_i,
  input  wire logic                                       hready_i,
  output logic [31:0]                                     hrdata_o,
  output logic                                            hreadyout_o,
  output logic                                            hresp_o,
  // motion side
  input  wire logic                                       contour_active_i,
  input  wire logic                                       contour_next_i,
  input  wire logic [aux_cmd_pkg::NUM_AXES-1:0]           move_start_i,
  input  wire logic [aux_cmd_pkg::NUM_AXES-1:0]           move_done_i,
  input  wire logic [aux_cmd_pkg::NUM_AXES*aux_cmd_pkg::POS_W-1:0] enc_pos_i,
  output logic [aux_cmd_pkg::NUM_AXES-1:0]                aux_o,
  output logic [aux_cmd_pkg::VEL_W-1:0]                   contour_vel_o,
  output logic [aux_cmd_pkg::NUM_AXES-1:0]                linear_ramp_o
);

  localparam int unsigned NA = aux_cmd_pkg::NUM_AXES;

  // ****************************************************************
  // input synchronisers for pin level motion signals
  // ****************************************************************
  logic          cact_s1_ff, cact_s2_ff, cnext_s1_ff, cnext_s2_ff, cnext_d_ff;
  logic [NA-1:0] mst_s1_ff, mst_s2_ff, mst_d_ff, mdn_s1_ff, mdn_s2_ff, mdn_d_ff;

  // two stage sync, then edge detect from second stage
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      {cact_s1_ff, cact_s2_ff, cnext_s1_ff, cnext_s2_ff, cnext_d_ff} <= '0;
      {mst_s1_ff, mst_s2_ff, mst_d_ff, mdn_s1_ff, mdn_s2_ff, mdn_d_ff} <= '0;
    end else begin
      {cact_s2_ff, cact_s1_ff}   <= {cact_s1_ff, contour_active_i};
      {cnext_s2_ff, cnext_s1_ff} <= {cnext_s1_ff, contour_next_i};
      cnext_d_ff                 <= cnext_s2_ff;
      {mst_s2_ff, mst_s1_ff}     <= {mst_s1_ff, move_start_i};
      {mdn_s2_ff, mdn_s1_ff}     <= {mdn_s1_ff, move_done_i};
      mst_d_ff                   <= mst_s2_ff;
      mdn_d_ff                   <= mdn_s2_ff;
    end
  end

  wire           cnext_pulse = cnext_s2_ff & ~cnext_d_ff;
  wire [NA-1:0]  mst_pulse   = mst_s2_ff & ~mst_d_ff;
  wire [NA-1:0]  mdn_pulse   = mdn_s2_ff & ~mdn_d_ff;

  // ****************************************************************
  // ahb-lite address phase capture
  // ****************************************************************
  logic       wr_pend_ff;
  logic [7:0] addr_ff;

  wire        ahb_go = hsel_i & hready_i & htrans_i[1];
  wire        wr_req = ahb_go & hwrite_i;

  // capture address; write data lands one cycle later
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_pend_ff <= 1'b0;
      addr_ff    <= '0;
    end else begin
      wr_pend_ff <= wr_req;
      if (ahb_go) begin
        addr_ff <= haddr_i[7:0];
      end
    end
  end

  // zero wait state, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // ****************************************************************
  // register decode
  // ****************************************************************
  wire wr_cmd  = wr_pend_ff & (addr_ff == aux_cmd_pkg::OFS_CMD);
  wire wr_arg  = wr_pend_ff & (addr_ff == aux_cmd_pkg::OFS_ARG);
  wire wr_axis = wr_pend_ff & (addr_ff == aux_cmd_pkg::OFS_AXIS);
  wire wr_hold = wr_pend_ff & (addr_ff == aux_cmd_pkg::OFS_HOLD);

  logic [31:0]                          arg_ff;
  logic [aux_cmd_pkg::AXIS_W-1:0]       axis_ff;
  logic                                 multi_ff;
  logic [aux_cmd_pkg::HOLD_W-1:0]       hold_ff;

  // argument, axis select and hold delay registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      arg_ff   <= '0;
      axis_ff  <= '0;
      multi_ff <= 1'b0;
      hold_ff  <= '0;
    end else begin
      if (wr_arg)  arg_ff <= hwdata_i;
      if (wr_axis) begin
        axis_ff  <= hwdata_i[aux_cmd_pkg::AXIS_W-1:0];
        multi_ff <= hwdata_i[aux_cmd_pkg::AXIS_MULTI_BIT];
      end
      if (wr_hold) hold_ff <= hwdata_i[aux_cmd_pkg::HOLD_W-1:0];
    end
  end

  wire [3:0] cmd_code = hwdata_i[3:0];
  wire c_speed = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_CONTOUR_SPEED);
  wire c_auto  = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_AUX_AUTO);
  wire c_query = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_AUX_QUERY) & ~multi_ff; // [R10]
  wire c_enc   = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_ENC_REPORT);
  wire c_lin   = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_LINEAR_RAMP);
  wire c_fhi   = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_FORCE_HIGH);
  wire c_flo   = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_FORCE_LOW);
  wire c_aon   = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_AUX_ON);
  wire c_aoff  = wr_cmd & (cmd_code == aux_cmd_pkg::CMD_AUX_OFF);

  // ****************************************************************
  // contour speed update
  // ****************************************************************
  wire [aux_cmd_pkg::VEL_W-1:0] arg_vel = arg_ff[aux_cmd_pkg::VEL_W-1:0];
  wire vel_ok = (arg_ff[31:aux_cmd_pkg::VEL_W] == '0) &
                (arg_vel >= aux_cmd_pkg::VEL_MIN) &
                (arg_vel <= aux_cmd_pkg::VEL_MAX);            // [R16]
  wire speed_take = c_speed & cact_s2_ff & vel_ok;            // [R2] [R16]

  logic [aux_cmd_pkg::VEL_W-1:0] pend_vel_ff;
  logic                          pend_ff;

  // pending velocity switches in at next contour command, no ramp
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_vel_ff   <= '0;
      pend_ff       <= 1'b0;
      contour_vel_o <= aux_cmd_pkg::VEL_MIN;
    end else begin
      if (cnext_pulse && pend_ff) begin
        contour_vel_o <= pend_vel_ff;                         // [R1]
      end
      if (speed_take) begin
        pend_vel_ff <= arg_vel;                               // [R1]
        pend_ff     <= 1'b1;
      end else if (cnext_pulse || !cact_s2_ff) begin
        pend_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // auto aux configuration per axis
  // ****************************************************************
  wire [NA-1:0] axis_onehot = NA'(1) << axis_ff;
  wire [NA-1:0] arg_mask    = arg_ff[aux_cmd_pkg::ARG_MASK_LSB +: NA];
  wire [NA-1:0] auto_sel    = multi_ff ? arg_mask : axis_onehot;  // [R7]
  wire [NA-1:0] auto_pols   = multi_ff ? arg_ff[NA-1:0]
                                       : {NA{arg_ff[0]}};          // [R4] [R7]
  wire          cancel_cmd  = c_aon | c_aoff | c_fhi | c_flo;
  wire [NA-1:0] cancel_sel  = multi_ff ? {NA{1'b1}} : axis_onehot;

  logic [NA-1:0] auto_en_ff, auto_pol_ff, lin_ff, force_ff, force_val_ff;
  logic [aux_cmd_pkg::POS_W-1:0] enc_snap_ff [NA];
  logic [NA-1:0] aux_w;

  genvar g;
  generate
    for (g = 0; g < NA; g++) begin : g_axis
      // mode bits; reset leaves auto off and ramps linear
      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          auto_en_ff[g]   <= 1'b0;                            // [R8]
          auto_pol_ff[g]  <= 1'b0;
          lin_ff[g]       <= 1'b1;                            // [R12]
          force_ff[g]     <= 1'b0;
          force_val_ff[g] <= 1'b0;
        end else begin
          force_ff[g] <= 1'b0;
          if (c_auto && auto_sel[g]) begin
            auto_en_ff[g]  <= 1'b1;                           // [R3] [R6] [R7]
            auto_pol_ff[g] <= auto_pols[g];                   // [R4]
          end else if (cancel_cmd && cancel_sel[g]) begin
            auto_en_ff[g] <= 1'b0;                            // [R6] [R14] [R15]
          end
          if ((c_fhi || c_flo) && cancel_sel[g]) begin
            force_ff[g]     <= 1'b1;
            force_val_ff[g] <= c_fhi;                         // [R14] [R15]
          end
          if (c_lin) begin
            lin_ff[g] <= 1'b1;                                // [R12]
          end
          if (c_enc) begin
            enc_snap_ff[g] <= enc_pos_i[g*aux_cmd_pkg::POS_W +: aux_cmd_pkg::POS_W]; // [R11]
          end
        end
      end

      aux_axis_ctrl u_axis (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .evt_i       ('{start: mst_pulse[g], done: mdn_pulse[g]}),
        .auto_en_i   (auto_en_ff[g]),
        .auto_pol_i  (auto_pol_ff[g]),
        .force_i     (force_ff[g]),
        .force_val_i (force_val_ff[g]),
        .hold_i      (hold_ff),
        .aux_o       (aux_w[g])
      );
    end
  endgenerate

  assign linear_ramp_o = lin_ff;

  // register the aux outputs
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) aux_o <= '0;
    else           aux_o <= aux_w;
  end

  // ****************************************************************
  // queue usage and query answer
  // ****************************************************************
  wire [aux_cmd_pkg::QCNT_W-1:0] n_auto = aux_cmd_pkg::QCNT_W'($countones(auto_sel));
  wire [aux_cmd_pkg::QCNT_W-1:0] auto_cost =
    (n_auto * aux_cmd_pkg::Q_AUTO_BASE) +
    ((hold_ff != '0) ? aux_cmd_pkg::Q_AUTO_SETTLE : '0);             // [R9]
  wire [aux_cmd_pkg::QCNT_W-1:0] cost =
    c_auto          ? auto_cost :
    c_lin           ? aux_cmd_pkg::Q_LINEAR_RAMP :                   // [R12]
    (c_fhi | c_flo) ? aux_cmd_pkg::Q_FORCE : '0;                     // [R14]

  logic [aux_cmd_pkg::QCNT_W-1:0] qcnt_ff;
  logic [2:0]                     query_ff;

  // queue entries used by the last command, query answer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      qcnt_ff  <= '0;
      query_ff <= '0;
    end else begin
      if (wr_cmd) qcnt_ff <= cost;
      if (c_query) begin
        query_ff <= {1'b1, ~auto_pol_ff[axis_ff], auto_en_ff[axis_ff]}; // [R10]
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [31:0] status_w = 32'(
      (aux_o << aux_cmd_pkg::ST_AUX_LSB) |
      (auto_en_ff << aux_cmd_pkg::ST_AUTO_LSB) |
      (auto_pol_ff << aux_cmd_pkg::ST_POL_LSB) |
      (lin_ff << aux_cmd_pkg::ST_LIN_LSB) |
      (32'(cact_s2_ff) << aux_cmd_pkg::ST_CONT_BIT));
  wire        rd_req = ahb_go & ~hwrite_i;
  wire [7:0]  ra     = haddr_i[7:0];
  wire [1:0]  enc_ix = ra[3:2];
  wire        is_enc = (ra[7:4] == aux_cmd_pkg::OFS_ENC_BASE[7:4]) &&
                       ({1'b0, ra[3:2]} < 3'(NA));
  wire [31:0] rd_mux =
    (ra == aux_cmd_pkg::OFS_AXIS)   ? 32'({multi_ff, 2'b00, axis_ff}) :
    (ra == aux_cmd_pkg::OFS_HOLD)   ? 32'(hold_ff) :
    (ra == aux_cmd_pkg::OFS_STATUS) ? status_w :
    (ra == aux_cmd_pkg::OFS_QUERY)  ? 32'(query_ff) :
    (ra == aux_cmd_pkg::OFS_VEL)    ? 32'(contour_vel_o) :
    (ra == aux_cmd_pkg::OFS_QCOUNT) ? 32'(qcnt_ff) :
    is_enc                          ? enc_snap_ff[enc_ix] : 32'h00000000;

  // read data registered at end of address phase
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i)   hrdata_o <= '0;
    else if (rd_req) hrdata_o <= rd_mux;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_RESET_AUTO_OFF: assert property (@(posedge mclk_i)  // [R8]
    $fell(sys_rst_i) |-> auto_en_ff == '0)
    else $error("auto aux enabled after reset");
  AST_SPEED_IDLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R2]
    (c_speed && !cact_s2_ff) |=> $stable(contour_vel_o) && !pend_ff)
    else $error("speed update acted without contour");
  AST_SPEED_RANGE: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R16]
    (c_speed && !vel_ok && !pend_ff) |=> !pend_ff)
    else $error("out of range speed accepted");
  AST_SPEED_APPLY: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R1]
    (cnext_pulse && pend_ff) |=> contour_vel_o == $past(pend_vel_ff))
    else $error("velocity not applied at next contour command");
  AST_FORCE_CANCEL: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R14]
    (c_fhi && !multi_ff) |=> !auto_en_ff[$past(axis_ff)] ##3 aux_o[$past(axis_ff,4)])
    else $error("force high failed");
  AST_FORCE_LOW: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R15]
    (c_flo && !multi_ff) |=> !auto_en_ff[$past(axis_ff)] ##3 !aux_o[$past(axis_ff,4)])
    else $error("force low failed");
  AST_LIN_COST: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R12]
    c_lin |=> qcnt_ff == aux_cmd_pkg::Q_LINEAR_RAMP && lin_ff == '1)
    else $error("linear ramp select wrong");
  AST_AUTO_COST: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R9]
    (c_auto && hold_ff == '0 && !multi_ff) |=> qcnt_ff == aux_cmd_pkg::Q_AUTO_BASE)
    else $error("auto aux queue cost wrong");
  AST_QUERY_MULTI: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R10]
    (wr_cmd && multi_ff) |=> $stable(query_ff))
    else $error("query answered in multi motor mode");
  AST_AUTO_SETTLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R9]
    (c_auto && hold_ff != '0 && !multi_ff) |=>
      qcnt_ff == aux_cmd_pkg::Q_AUTO_BASE + aux_cmd_pkg::Q_AUTO_SETTLE)
    else $error("settle queue cost wrong");
  AST_FORCE_COST: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R14]
    (c_fhi || c_flo) |=> qcnt_ff == aux_cmd_pkg::Q_FORCE)
    else $error("force queue cost wrong");
  AST_ENC_SNAP: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R11]
    c_enc |=> enc_snap_ff[0] == $past(enc_pos_i[aux_cmd_pkg::POS_W-1:0]))
    else $error("encoder snapshot wrong");
  AST_MULTI_SEL: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R7]
    (c_auto && multi_ff) |=> (auto_en_ff & $past(arg_mask)) == $past(arg_mask))
    else $error("multi auto select wrong");
  AST_MULTI_CANCEL: assert property (@(posedge mclk_i) disable iff (sys_rst_i) // [R6]
    ((c_aon || c_aoff) && multi_ff) |=> auto_en_ff == '0)
    else $error("multi cancel failed");

endmodule : aux_cmd_ctrl

/* File: src/aux_cmd_pkg.sv */
// package: constants, register map and types for the aux output command block
package aux_cmd_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int unsigned NUM_AXES   = 4;
  localparam int unsigned AXIS_W     = 2;
  localparam int unsigned VEL_W      = 20;
  localparam int unsigned POS_W      = 32;
  localparam int unsigned QCNT_W     = 8;
  localparam int unsigned HOLD_W     = 16;

  // ****************************************************************
  // velocity range and queue entry costs
  // ****************************************************************
  localparam logic [VEL_W-1:0]  VEL_MIN        = 20'h00001;
  localparam logic [VEL_W-1:0]  VEL_MAX        = 20'hFEE1F;  // 1,043,999
  localparam logic [QCNT_W-1:0] Q_AUTO_BASE    = 8'h01;
  localparam logic [QCNT_W-1:0] Q_AUTO_SETTLE  = 8'h03;
  localparam logic [QCNT_W-1:0] Q_LINEAR_RAMP  = 8'h0B;      // 11 entries
  localparam logic [QCNT_W-1:0] Q_FORCE        = 8'h01;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CMD      = 8'h00;  // write: command code
  localparam logic [7:0] OFS_ARG      = 8'h04;  // write: command argument
  localparam logic [7:0] OFS_AXIS     = 8'h08;  // axis select and mode
  localparam logic [7:0] OFS_HOLD     = 8'h0C;  // aux hold delay in cycles
  localparam logic [7:0] OFS_STATUS   = 8'h10;  // read: aux/auto/ramp state
  localparam logic [7:0] OFS_QUERY    = 8'h14;  // read: last query answer
  localparam logic [7:0] OFS_VEL      = 8'h18;  // read: contour velocity
  localparam logic [7:0] OFS_QCOUNT   = 8'h1C;  // read: queue entries used
  localparam logic [7:0] OFS_ENC_BASE = 8'h20;  // read: encoder snapshot x4

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned AXIS_MULTI_BIT = 4;   // OFS_AXIS: multi motor mode
  localparam int unsigned ARG_MASK_LSB   = 4;   // PA multi: filled axes mask
  localparam int unsigned ST_AUX_LSB     = 0;
  localparam int unsigned ST_AUTO_LSB    = 4;
  localparam int unsigned ST_POL_LSB     = 8;
  localparam int unsigned ST_LIN_LSB     = 12;
  localparam int unsigned ST_CONT_BIT    = 16;
  localparam int unsigned Q_VALID_BIT    = 2;
  localparam int unsigned Q_POL_BIT      = 1;
  localparam int unsigned Q_EN_BIT       = 0;

  // ****************************************************************
  // command codes
  // ****************************************************************
  typedef enum logic [3:0] {
    CMD_NONE          = 4'h0,
    CMD_CONTOUR_SPEED = 4'h1,
    CMD_AUX_AUTO      = 4'h2,
    CMD_AUX_QUERY     = 4'h3,
    CMD_ENC_REPORT    = 4'h4,
    CMD_LINEAR_RAMP   = 4'h5,
    CMD_FORCE_HIGH    = 4'h6,
    CMD_FORCE_LOW     = 4'h7,
    CMD_AUX_ON        = 4'h8,
    CMD_AUX_OFF       = 4'h9
  } cmd_e;

  // ****************************************************************
  // per axis motion event carrier
  // ****************************************************************
  typedef struct packed {
    logic start;  // move start (go or deferred go)
    logic done;   // move finished
  } move_evt_s;

endpackage : aux_cmd_pkg

/* File: src/aux_axis_ctrl.sv */
// module: per axis automatic aux output sequencer with hold delay
`timescale 1ns/1ps
module aux_axis_ctrl (
  input  wire logic                              mclk_i,
  input  wire logic                              sys_rst_i,
  input  wire aux_cmd_pkg::move_evt_s            evt_i,
  input  wire logic                              auto_en_i,
  input  wire logic                              auto_pol_i,
  input  wire logic                              force_i,
  input  wire logic                              force_val_i,
  input  wire logic [aux_cmd_pkg::HOLD_W-1:0]    hold_i,
  output logic                                   aux_o
);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_HOLD = 2'b10
  } seq_e;

  seq_e                              state_ff;
  logic [aux_cmd_pkg::HOLD_W-1:0]    hold_cnt_ff;
  wire                               hold_done = (hold_cnt_ff == '0);
  wire                               move_lvl  = ~auto_pol_i;

  // aux level, state and settle counter
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_ff    <= ST_IDLE;
      hold_cnt_ff <= '0;
      aux_o       <= 1'b0;
    end else if (force_i) begin
      state_ff <= ST_IDLE;
      aux_o    <= force_val_i;
    end else if (!auto_en_i) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (evt_i.start) begin
            aux_o    <= move_lvl;       // level during move [R3] [R4]
            state_ff <= ST_MOVE;
          end else begin
            aux_o <= ~move_lvl;         // idle level once auto is on [R3] [R4]
          end
        end
        ST_MOVE: begin
          if (evt_i.done) begin
            hold_cnt_ff <= hold_i;      // settle before complement [R5]
            state_ff    <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (hold_done) begin
            aux_o    <= ~move_lvl;      // complement at move end [R3] [R4]
            state_ff <= ST_IDLE;
          end else begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule : aux_axis_ctrl

/* File: tb/motion_model.sv */
// motion side model: contour state, axis moves and encoder counts
`timescale 1ns/1ps
module motion_model (
  input  wire logic         mclk_i,
  output logic              contour_active_o,
  output logic              contour_next_o,
  output logic [3:0]        move_start_o,
  output logic [3:0]        move_done_o,
  output logic [127:0]      enc_pos_o
);
  // ****************************************************************
  // idle levels and fixed encoder counts
  // ****************************************************************
  initial begin
    contour_active_o = 1'b0;
    contour_next_o   = 1'b0;
    move_start_o     = 4'h0;
    move_done_o      = 4'h0;
    enc_pos_o        = {32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111};
  end
  // contour running level
  task automatic set_contour(input logic on);
    contour_active_o <= on;
    repeat (4) @(posedge mclk_i);
  endtask : set_contour
  // one rising edge on the next contour command line
  task automatic next_cmd();
    contour_next_o <= 1'b1;
    repeat (3) @(posedge mclk_i);
    contour_next_o <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask : next_cmd
  // move start and move finish edges
  task automatic start(input int ax);
    move_done_o[ax]  <= 1'b0;
    move_start_o[ax] <= 1'b1;
  endtask : start
  task automatic set_enc(input logic [127:0] v);
    enc_pos_o <= v;
  endtask : set_enc
  task automatic finish(input int ax);
    move_start_o[ax] <= 1'b0;
    move_done_o[ax]  <= 1'b1;
  endtask : finish
endmodule : motion_model

/* File: tb/aux_cmd_ctrl_test.sv */
// testbench: aux output and ramp command interpreter
`timescale 1ns/1ps
module aux_cmd_ctrl_test;
  logic         mclk_i;
  logic         sys_rst_i;
  logic [31:0]  haddr, hwdata, hrdata, q;
  logic [1:0]   htrans;
  logic [2:0]   hsz;
  logic         hwrite, hrdy, hresp, c_act, c_nxt, hsel;
  logic [3:0]   m_st, m_dn, aux, lin;
  logic [127:0] enc;
  logic [19:0]  vel;
  int           mismatches, n_compared;

  aux_cmd_ctrl uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsz), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .contour_active_i(c_act),
    .contour_next_i(c_nxt), .move_start_i(m_st), .move_done_i(m_dn), .enc_pos_i(enc),
    .aux_o(aux), .contour_vel_o(vel), .linear_ramp_o(lin));
  motion_model mm (.mclk_i(mclk_i), .contour_active_o(c_act), .contour_next_o(c_nxt),
    .move_start_o(m_st), .move_done_o(m_dn), .enc_pos_o(enc));

  // ****************************************************************
  // clock, bus cycles and compare
  // ****************************************************************
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    {hsel, hsz, htrans} <= {1'b1, 3'h2, 2'h2};
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk_i); while (hrdy !== 1'b1);
    {hsel, htrans} <= '0;
    hwdata <= d;
    do @(posedge mclk_i); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chkr(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : chkr
  task automatic cmd(input aux_cmd_pkg::cmd_e c, input logic [31:0] arg);
    bus(1'b1, aux_cmd_pkg::OFS_ARG, arg);
    bus(1'b1, aux_cmd_pkg::OFS_CMD, {28'h0, c});
  endtask : cmd

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_speed();
    cmd(aux_cmd_pkg::CMD_CONTOUR_SPEED, 32'h7530);
    wt(6);
    chk(32'(vel), 32'h1);
    mm.set_contour(1'b1);
    cmd(aux_cmd_pkg::CMD_CONTOUR_SPEED, 32'h0);
    cmd(aux_cmd_pkg::CMD_CONTOUR_SPEED, 32'hFEE20);
    mm.next_cmd();
    chk(32'(vel), 32'h1);
    cmd(aux_cmd_pkg::CMD_CONTOUR_SPEED, 32'hFEE1F);
    wt(6);
    chk(32'(vel), 32'h1);
    mm.next_cmd();
    chk(32'(vel), 32'hFEE1F);
    mm.set_contour(1'b0);
  endtask : t_speed
  task automatic t_auto(input logic pol, input logic [31:0] hold, input logic [31:0] qn);
    bus(1'b1, aux_cmd_pkg::OFS_HOLD, hold);
    cmd(aux_cmd_pkg::CMD_AUX_AUTO, {31'h0, pol});
    chkr(aux_cmd_pkg::OFS_QCOUNT, qn);
    wt(8);
    chk(32'(aux), {31'h0, pol});
    mm.start(0);
    wt(8);
    chk(32'(aux), {31'h0, ~pol});
    mm.finish(0);
    wt(8);
    chk(32'(aux), {31'h0, (hold != 0) ? ~pol : pol});
    wt(30);
    chk(32'(aux), {31'h0, pol});
    cmd(aux_cmd_pkg::CMD_AUX_QUERY, 32'h0);
    chkr(aux_cmd_pkg::OFS_QUERY, {29'h0, 1'b1, ~pol, 1'b1});
  endtask : t_auto
  task automatic t_force();
    cmd(aux_cmd_pkg::CMD_FORCE_LOW, 32'h0);
    mm.start(0);
    wt(8);
    chk(32'(aux), 32'h0);
    mm.finish(0);
    cmd(aux_cmd_pkg::CMD_FORCE_HIGH, 32'h0);
    chkr(aux_cmd_pkg::OFS_QCOUNT, 32'h1);
    wt(6);
    chk(32'(aux), 32'h1);
    chkr(aux_cmd_pkg::OFS_STATUS, 32'h0000F101);
  endtask : t_force
  task automatic t_report();
    cmd(aux_cmd_pkg::CMD_ENC_REPORT, 32'h0);
    mm.set_enc('0);
    for (int i = 0; i < 4; i++) begin
      chkr(aux_cmd_pkg::OFS_ENC_BASE + 8'(4 * i), 32'h11111111 * (i + 1));
    end
    cmd(aux_cmd_pkg::CMD_LINEAR_RAMP, 32'h0); // all axes idle here
    chkr(aux_cmd_pkg::OFS_QCOUNT, 32'hB);
    chk(32'(lin), 32'hF);
  endtask : t_report
  task automatic t_multi();
    bus(1'b1, aux_cmd_pkg::OFS_AXIS, 32'h10);
    cmd(aux_cmd_pkg::CMD_AUX_AUTO, 32'h22);
    cmd(aux_cmd_pkg::CMD_AUX_QUERY, 32'h0);
    chkr(aux_cmd_pkg::OFS_QUERY, 32'h5);
    chkr(aux_cmd_pkg::OFS_STATUS, 32'h0000F323);
    cmd(aux_cmd_pkg::CMD_AUX_OFF, 32'h0);
    chkr(aux_cmd_pkg::OFS_STATUS, 32'h0000F303);
  endtask : t_multi
  task automatic results();
    if (mismatches == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ****************************************************************
  // watchdog and main sequence
  // ****************************************************************
  initial begin
    #3000000;
    mismatches++;
    results();
  end
  initial begin
    sys_rst_i = 1'b1;
    {haddr, hwdata, htrans, hwrite, hsel, hsz} = '0;
    wt(10);
    sys_rst_i <= 1'b0;
    wt(1);
    chkr(aux_cmd_pkg::OFS_STATUS, 32'h0000F000);
    chkr(aux_cmd_pkg::OFS_VEL, 32'h1);
    t_speed();
    t_auto(1'b0, 32'h0, 32'h1);
    t_auto(1'b1, 32'h14, 32'h4);
    t_force();
    t_report();
    t_multi();
    results();
  end
endmodule : aux_cmd_ctrl_test
